// file: prc_pkg.sv
// Purpose: constants and carrier types for the peripheral reset / clock control block
// Assumes: APB, 32-bit data, byte offsets as printed
// Notes:   timing counts in system clock cycles at 200 MHz
package prc_pkg;
    localparam logic [11:0] RST_CTRL_OFS  = 12'h004;
    localparam logic [11:0] CLK_CTRL_OFS  = 12'h008;

    localparam int          RST_NUM       = 8;
    localparam logic [7:0]  RST_WR_MASK   = 8'hEF;
    localparam logic [7:0]  RST_RESET_VAL = 8'h00;

    localparam int          EXTCLK_RDY_BIT = 31;
    localparam int          INRO_RDY_BIT   = 29;
    localparam int          BAUD_RDY_BIT   = 28;
    localparam int          PRIM_RDY_BIT   = 27;
    localparam int          RTCX_RDY_BIT   = 25;
    localparam int          HFX_RDY_BIT    = 24;
    localparam int          BAUD_VS_BIT    = 21;
    localparam int          BAUD_EN_BIT    = 20;
    localparam int          PRIM_EN_BIT    = 19;
    localparam int          KEEP_LO_BIT    = 17;
    localparam logic        BAUD_EN_RST    = 1'b0;
    localparam logic        PRIM_EN_RST    = 1'b1;
    localparam logic        BAUD_VS_RST    = 1'b0;
    localparam logic [1:0]  KEEP_RST       = 2'h0;

    localparam int          CLK_MHZ        = 200;
    localparam int          RST_HOLD_NS    = 40;
    localparam int          RST_HOLD_CYC   = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0]  RST_HOLD_LAST  = 4'(RST_HOLD_CYC - 1);

    typedef struct packed {
        logic extclk;
        logic inro;
        logic baud;
        logic prim;
        logic rtcx;
        logic hfx;
    } osc_rdy_t;

    typedef struct packed {
        logic baud_vs;
        logic baud_en;
        logic prim_en;
    } osc_ctrl_t;
endpackage

// file: prc_rst_chan.sv
// Purpose: one peripheral reset channel with self-clearing request
// Assumes: synchronous active-high system reset
// Notes:   reset held a fixed count of cycles, then bit clears
`timescale 1ns/1ps
`default_nettype none
module prc_rst_chan (
    input  wire logic i_mclk,   // system clock
    input  wire logic i_rst,    // sync reset
    input  wire logic i_start,  // software wrote one
    output logic      o_busy    // reset in progress
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       busy_q;
    logic       busy_d;

    always_comb begin
        busy_d = busy_q;
        cnt_d  = cnt_q;
        if (busy_q) begin
            if (cnt_q == prc_pkg::RST_HOLD_LAST) begin
                busy_d = 1'b0;
                cnt_d  = 4'h0;
            end else begin
                cnt_d = cnt_q + 4'h1;
            end
        end else if (i_start) begin
            busy_d = 1'b1;
            cnt_d  = 4'h0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            busy_q <= 1'b0;
            cnt_q  <= 4'h0;
        end else begin
            busy_q <= busy_d;
            cnt_q  <= cnt_d;
        end
    end

    assign o_busy = busy_q;
endmodule
`default_nettype wire

// file: periph_reset_clock_ctrl.sv
// Purpose: peripheral reset requests and oscillator control/status over APB
// Assumes: oscillator ready inputs synchronous to i_mclk
// Notes:   zero-wait APB slave; unmapped addresses read zero, pslverr set
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module periph_reset_clock_ctrl (
    input  wire logic              i_mclk,         // system clock
    input  wire logic              i_rst,          // sync reset, high
    input  wire logic              i_psel,         // apb select
    input  wire logic              i_penable,      // apb enable
    input  wire logic              i_pwrite,       // apb write
    input  wire logic [11:0]       i_paddr,        // apb byte address
    input  wire logic [31:0]       i_pwdata,       // apb write data
    output logic      [31:0]       o_prdata,       // apb read data
    output logic                   o_pready,       // apb ready
    output logic                   o_pslverr,      // apb error
    input  wire prc_pkg::osc_rdy_t i_osc_rdy,      // raw oscillator ready
    input  wire logic              i_baud_vs_done, // supply returned to default
    output logic      [7:0]        o_periph_rst,   // per-peripheral reset
    output prc_pkg::osc_ctrl_t     o_osc_ctrl      // oscillator controls
);
    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic setup;
    logic wr_rst;
    logic wr_clk;
    logic hit;

    assign setup  = i_psel && !i_penable;
    assign hit    = (i_paddr == prc_pkg::RST_CTRL_OFS) || (i_paddr == prc_pkg::CLK_CTRL_OFS);
    assign wr_rst = setup && i_pwrite && (i_paddr == prc_pkg::RST_CTRL_OFS);
    assign wr_clk = setup && i_pwrite && (i_paddr == prc_pkg::CLK_CTRL_OFS);

    // ------------------------------------------------------------
    // peripheral reset channels
    // ------------------------------------------------------------
    logic [7:0] busy;
    logic [7:0] prst_q;
    logic [7:0] prst_d;

    genvar g;
    generate
        for (g = 0; g < prc_pkg::RST_NUM; g++) begin : g_chan
            if (prc_pkg::RST_WR_MASK[g]) begin : g_live
                prc_rst_chan u_chan (
                    .i_mclk  (i_mclk),
                    .i_rst   (i_rst),
                    .i_start (wr_rst && i_pwdata[g]),
                    .o_busy  (busy[g])
                );
            end else begin : g_resv
                assign busy[g] = 1'b0;
            end
        end
    endgenerate

    always_comb begin
        prst_d = busy | (wr_rst ? (i_pwdata[7:0] & prc_pkg::RST_WR_MASK) : 8'h00);
    end

    // ------------------------------------------------------------
    // clock control state
    // ------------------------------------------------------------
    prc_pkg::osc_ctrl_t ctrl_q;
    prc_pkg::osc_ctrl_t ctrl_d;
    logic [1:0]         keep_q;
    logic [1:0]         keep_d;
    prc_pkg::osc_rdy_t  rdy_q;
    prc_pkg::osc_rdy_t  rdy_d;

    always_comb begin
        ctrl_d = ctrl_q;
        keep_d = keep_q;
        if (wr_clk) begin
            ctrl_d.baud_vs = i_pwdata[prc_pkg::BAUD_VS_BIT];
            ctrl_d.baud_en = i_pwdata[prc_pkg::BAUD_EN_BIT];
            ctrl_d.prim_en = i_pwdata[prc_pkg::PRIM_EN_BIT];
            keep_d = i_pwdata[prc_pkg::KEEP_LO_BIT +: 2];
        end
        if (i_baud_vs_done) begin
            ctrl_d.baud_vs = 1'b0;
        end
        // flags gated by enables; external and other oscillators by their own ready
        rdy_d        = i_osc_rdy;
        rdy_d.baud   = i_osc_rdy.baud && ctrl_q.baud_en;
        rdy_d.prim   = i_osc_rdy.prim && ctrl_q.prim_en;
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        ready_d;
    logic        ready_q;
    logic        err_d;
    logic        err_q;
    logic        rd_req;

    assign rd_req = setup && !i_pwrite;

    always_comb begin
        ready_d = setup;
        err_d   = setup && !hit;
        // read data held until the next read setup
        rdata_d = rdata_q;
        if (rd_req) begin
            rdata_d = 32'h0000_0000;
        end
        if (rd_req && (i_paddr == prc_pkg::RST_CTRL_OFS)) begin
            rdata_d[7:0] = busy;
        end else if (rd_req && (i_paddr == prc_pkg::CLK_CTRL_OFS)) begin
            rdata_d[prc_pkg::EXTCLK_RDY_BIT] = rdy_q.extclk;
            rdata_d[prc_pkg::INRO_RDY_BIT]   = rdy_q.inro;
            rdata_d[prc_pkg::BAUD_RDY_BIT]   = rdy_q.baud;
            rdata_d[prc_pkg::PRIM_RDY_BIT]   = rdy_q.prim;
            rdata_d[prc_pkg::RTCX_RDY_BIT]   = rdy_q.rtcx;
            rdata_d[prc_pkg::HFX_RDY_BIT]    = rdy_q.hfx;
            rdata_d[prc_pkg::BAUD_VS_BIT]    = ctrl_q.baud_vs;
            rdata_d[prc_pkg::BAUD_EN_BIT]    = ctrl_q.baud_en;
            rdata_d[prc_pkg::PRIM_EN_BIT]    = ctrl_q.prim_en;
            rdata_d[prc_pkg::KEEP_LO_BIT +: 2] = keep_q;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl_q  <= '{baud_vs: prc_pkg::BAUD_VS_RST,
                         baud_en: prc_pkg::BAUD_EN_RST,
                         prim_en: prc_pkg::PRIM_EN_RST};
            keep_q  <= prc_pkg::KEEP_RST;
            rdy_q   <= '0;
            prst_q  <= prc_pkg::RST_RESET_VAL;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            keep_q  <= keep_d;
            rdy_q   <= rdy_d;
            prst_q  <= prst_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
        end
    end

    assign o_prdata     = rdata_q;
    assign o_pready     = ready_q;
    assign o_pslverr    = err_q;
    assign o_periph_rst = prst_q;
    assign o_osc_ctrl   = ctrl_q;
endmodule
`default_nettype wire

// file: periph_reset_clock_ctrl_checker.sv
// Purpose: port assertions
// Assumes: zero-wait apb slave
// Notes:   bound at the foot
`timescale 1ns/1ps
`default_nettype none
module periph_reset_clock_ctrl_checker (
    input wire logic               i_mclk,         // clk
    input wire logic               i_rst,          // rst
    input wire logic               i_psel,         // sel
    input wire logic               i_penable,      // en
    input wire logic               i_pwrite,       // wr
    input wire logic [11:0]        i_paddr,        // addr
    input wire logic [31:0]        i_pwdata,       // wdata
    input wire logic               o_pready,       // ready
    input wire logic               o_pslverr,      // err
    input wire logic               i_baud_vs_done, // supply back
    input wire logic [7:0]         o_periph_rst,   // resets
    input wire prc_pkg::osc_ctrl_t o_osc_ctrl      // osc ctrl
);
    // ----
    // checks
    // ----
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    wire logic setup = i_psel && !i_penable;
    wire logic wr4   = setup && i_pwrite && i_paddr == 12'h004;
    wire logic wr8   = setup && i_pwrite && i_paddr == 12'h008;
    a_pready_setup: assert property (o_pready == $past(setup))
        else $error("pready timing");
    a_rst_start: assert property (wr4 && i_pwdata[0] |=> o_periph_rst[0])
        else $error("reset not started");
    a_rst_cause: assert property ($rose(o_periph_rst[5]) |-> $past(wr4 && i_pwdata[5]))
        else $error("reset without write");
    a_rst_self_clear: assert property ($rose(o_periph_rst[5]) |->
        o_periph_rst[5] [*8] ##[1:2] !o_periph_rst[5])
        else $error("reset length");
    a_bit4_quiet: assert property (!o_periph_rst[4])
        else $error("bit4 reset");
    a_ctrl_reset: assert property ($past(i_rst) |-> o_osc_ctrl == 3'h1)
        else $error("ctrl reset value");
    a_vs_auto_clear: assert property (i_baud_vs_done |=> !o_osc_ctrl.baud_vs)
        else $error("supply select kept");
    a_en_written: assert property (wr8 |=> o_osc_ctrl.baud_en == $past(i_pwdata[20])
        && o_osc_ctrl.prim_en == $past(i_pwdata[19]))
        else $error("enable write");
    a_unmapped_err: assert property (setup && i_paddr != 12'h004 && i_paddr != 12'h008
        |=> o_pslverr)
        else $error("no slave error");
    c_rst_done: cover property ($fell(o_periph_rst[5]));
    c_vs_done: cover property (i_baud_vs_done);
    c_err: cover property (o_pslverr);
endmodule
bind periph_reset_clock_ctrl periph_reset_clock_ctrl_checker checker_i (.*);
`default_nettype wire

// file: osc_partner.sv
// Purpose: oscillator side model
// Assumes: ready levels synchronous
// Notes:   baud oscillator slow, primary prompt
`timescale 1ns/1ps
`default_nettype none
module osc_partner (
    input  wire logic               i_mclk, // clk
    input  wire logic               i_rst,  // rst
    input  wire prc_pkg::osc_ctrl_t i_ctrl, // enables
    input  wire logic [3:0]         i_on,   // ext, inro, rtc, hf running
    output prc_pkg::osc_rdy_t       o_rdy,  // ready levels
    output logic                    o_done  // supply back to default
);
    logic [3:0] warm_q;
    logic [3:0] vs_q;
    always_ff @(posedge i_mclk) begin
        warm_q <= (i_rst || !i_ctrl.baud_en) ? 4'h0 : warm_q + {3'h0, warm_q != 4'hF};
        vs_q   <= (i_rst || !i_ctrl.baud_vs) ? 4'h0 : vs_q + 4'h1;
    end
    assign o_rdy  = {i_on[3:2], warm_q > 4'h4, i_ctrl.prim_en, i_on[1:0]};
    assign o_done = vs_q == 4'h6;
endmodule
`default_nettype wire

// file: test_periph_reset_clock_ctrl.sv
// Purpose: self-checking bench
// Assumes: oscillator model on the far side
// Notes:   reset hold of 8 cycles
`timescale 1ns/1ps
`default_nettype none
module test_periph_reset_clock_ctrl;
    logic               i_mclk, i_rst, psel, penable, pwrite, pready, pslverr, err, done;
    logic        [11:0] paddr;
    logic        [31:0] pwdata, prdata, rd;
    logic        [7:0]  prst;
    logic        [3:0]  on;
    prc_pkg::osc_rdy_t  rdy;
    prc_pkg::osc_ctrl_t ctrl;
    int                 mismatches = 0, n_compared = 0, cycles = 0;
    periph_reset_clock_ctrl periph_reset_clock_ctrl_i (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_osc_rdy(rdy), .i_baud_vs_done(done), .o_periph_rst(prst),
        .o_osc_ctrl(ctrl));
    osc_partner osc_partner_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_ctrl(ctrl), .i_on(on),
        .o_rdy(rdy), .o_done(done));
    // ----
    // tasks
    // ----
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge i_mclk);
        penable <= 1'b1;
        do @(posedge i_mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, on} = '0;
        i_rst = 1'b1;
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0808_0000);
        apb(1'b1, 12'h004, 32'h0000_00FF);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0000_00EF);
        chk({24'h0, prst}, 32'h0000_00EF);
        repeat (12) @(posedge i_mclk);
        apb(1'b1, 12'h004, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd | {24'h0, prst}, 32'h0);
        on <= 4'hF;
        apb(1'b0, 12'h008, 32'h0);
        apb(1'b1, 12'h008, (rd & 32'h0006_0000) | 32'h44F0_0000);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'hA330_0000);
        repeat (12) @(posedge i_mclk);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'hB310_0000);
        chk({29'h0, ctrl}, 32'h2);
        on <= 4'h0;
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h1010_0000);
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        i_rst <= 1'b1;
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0808_0000);
        chk({29'h0, ctrl}, 32'h1);
        complete_run();
    end
endmodule
`default_nettype wire
